// ### hw/slcr_regs.sv
// serial link configuration register bank
`timescale 1ns/10ps
module slcr_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // sync pins
   input wire logic single_ended_sync_pin_n,
   input wire logic timestamp_diff_input_n,
   // link side
   output slcr_pkg::slcr_link_cfg_t link_cfg,
   // change record stream
   output logic change_valid,
   input wire logic change_ready,
   output slcr_pkg::slcr_word_t change_word,
   output logic write_dropped
);
   // ***************************************
   // state
   // ***************************************
   typedef enum logic [1:0] {
      LNK_OFF,
      LNK_ON
   } slcr_lnk_t;
   typedef struct packed {
      logic link_enable;
      logic cal_enable;
      logic [4:0] link_output_mode;
      logic [4:0] multiframe_length;
      logic software_sync_request;
      logic [1:0] sync_source;
      logic sample_encoding;
      logic scrambler_enable;
      logic [3:0] lane_test_pattern;
      logic [7:0] link_device_ident;
      logic timestamp_receiver_enable;
      logic [1:0] se_sync;
      logic [1:0] ts_sync;
      logic [7:0] rdata;
      logic dropped;
      logic link_hold;
      logic test_reserved;
      logic [7:0] ident_b;
      logic sync_request;
      slcr_lnk_t lnk;
   } slcr_st_t;
   slcr_st_t st;
   slcr_st_t next_st;
   logic fifo_in_ready;
   logic [15:0] fifo_out;
   slcr_pkg::slcr_word_t rec;

   function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // pin per source; reserved code 3 falls back to software only, like code 2
   function automatic logic pin_request(input logic [1:0] src, input logic se_n,
      input logic ts_n);
      case (src)
         slcr_pkg::SYNC_SRC_SINGLE_ENDED: return !se_n;
         slcr_pkg::SYNC_SRC_TIMESTAMP: return !ts_n;
         default: return 1'b0;
      endcase
   endfunction

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      next_st = st;
      next_st.se_sync = {st.se_sync[0], single_ended_sync_pin_n};
      next_st.ts_sync = {st.ts_sync[0], timestamp_diff_input_n};
      next_st.dropped = 1'b0;
      if (reg_wr) begin
         if (!fifo_in_ready) begin
            next_st.dropped = 1'b1;
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_LINK_ENABLE)) begin
            next_st.link_enable = reg_wdata[0];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_CAL_ENABLE)) begin
            next_st.cal_enable = reg_wdata[0];
            next_st.timestamp_receiver_enable = reg_wdata[1];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_LINK_OUTPUT_MODE) && !st.link_enable
            && !st.cal_enable) begin
            next_st.link_output_mode = reg_wdata[4:0];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_MULTIFRAME_LENGTH)) begin
            next_st.multiframe_length = reg_wdata[4:0];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_SOFTWARE_SYNC_REQUEST)) begin
            next_st.software_sync_request = reg_wdata[0];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_LINK_CONTROL)) begin
            next_st.sync_source = reg_wdata[slcr_pkg::POS_SYNC_SOURCE +: 2];
            next_st.sample_encoding = reg_wdata[slcr_pkg::POS_SAMPLE_ENCODING];
            next_st.scrambler_enable = reg_wdata[slcr_pkg::POS_SCRAMBLER_ENABLE];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_LANE_TEST_PATTERN)) begin
            next_st.lane_test_pattern = reg_wdata[3:0];
         end
         if (is_addr(reg_addr, slcr_pkg::OFS_LINK_DEVICE_IDENT)) begin
            next_st.link_device_ident = {reg_wdata[7:1], 1'b0};
         end
      end
      case (st.lnk)
         LNK_OFF: begin
            if (st.link_enable) begin
               next_st.lnk = LNK_ON;
            end
         end
         LNK_ON: begin
            if (!st.link_enable) begin
               next_st.lnk = LNK_OFF;
            end
         end
         default: begin
            next_st.lnk = LNK_OFF;
         end
      endcase
      // derived outputs come from next values, so they register on the same edge as their fields
      // held also in the cycle the enable drops
      next_st.link_hold = !next_st.link_enable || (next_st.lnk != LNK_ON);
      next_st.test_reserved = (next_st.lane_test_pattern > slcr_pkg::TEST_HOLD_HIGH);
      // link b ident one above link a
      next_st.ident_b = next_st.link_device_ident + 8'h01;
      // software request always honoured, pin only when selected
      next_st.sync_request = !next_st.software_sync_request
         || pin_request(next_st.sync_source, next_st.se_sync[1], next_st.ts_sync[1]);
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            slcr_pkg::OFS_LINK_ENABLE: next_st.rdata = {7'h00, st.link_enable};
            slcr_pkg::OFS_LINK_OUTPUT_MODE: next_st.rdata = {3'h0, st.link_output_mode};
            slcr_pkg::OFS_MULTIFRAME_LENGTH: next_st.rdata = {3'h0, st.multiframe_length};
            slcr_pkg::OFS_SOFTWARE_SYNC_REQUEST: begin
               next_st.rdata = {7'h00, st.software_sync_request};
            end
            slcr_pkg::OFS_LINK_CONTROL: begin
               next_st.rdata = {4'h0, st.sync_source, st.sample_encoding,
                  st.scrambler_enable};
            end
            slcr_pkg::OFS_LANE_TEST_PATTERN: next_st.rdata = {4'h0, st.lane_test_pattern};
            slcr_pkg::OFS_LINK_DEVICE_IDENT: next_st.rdata = st.link_device_ident;
            slcr_pkg::OFS_CAL_ENABLE: begin
               next_st.rdata = {6'h00, st.timestamp_receiver_enable, st.cal_enable};
            end
            slcr_pkg::OFS_LINK_STATUS: begin
               next_st.rdata = {5'h00, st.sync_request, st.lnk == LNK_ON,
                  st.link_enable};
            end
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
         st.link_enable <= slcr_pkg::RST_LINK_ENABLE[0];
         st.cal_enable <= slcr_pkg::RST_CAL_ENABLE;
         st.link_output_mode <= slcr_pkg::RST_LINK_OUTPUT_MODE;
         st.multiframe_length <= slcr_pkg::RST_MULTIFRAME_LENGTH;
         st.software_sync_request <= slcr_pkg::RST_SOFTWARE_SYNC_REQUEST;
         st.sync_source <= slcr_pkg::RST_SYNC_SOURCE;
         st.sample_encoding <= slcr_pkg::RST_SAMPLE_ENCODING;
         st.scrambler_enable <= slcr_pkg::RST_SCRAMBLER_ENABLE;
         st.lane_test_pattern <= slcr_pkg::RST_LANE_TEST_PATTERN;
         st.link_device_ident <= slcr_pkg::RST_LINK_DEVICE_IDENT;
         st.ident_b <= slcr_pkg::RST_LINK_DEVICE_IDENT + 8'h01;
         st.link_hold <= 1'b1;
         st.se_sync <= 2'h3;
         st.ts_sync <= 2'h3;
         st.lnk <= LNK_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   always_comb begin
      link_cfg = '0;
      link_cfg.link_enable = st.link_enable;
      link_cfg.link_hold_reset = st.link_hold;
      link_cfg.link_output_mode = st.link_output_mode;
      link_cfg.multiframe_length = st.multiframe_length;
      link_cfg.sample_encoding = st.sample_encoding;
      link_cfg.scrambler_enable = st.scrambler_enable;
      link_cfg.lane_test_pattern = st.lane_test_pattern;
      link_cfg.test_reserved = st.test_reserved;
      link_cfg.ident_link_a = st.link_device_ident;
      link_cfg.ident_link_b = st.ident_b;
      link_cfg.timestamp_receiver_enable = st.timestamp_receiver_enable;
      link_cfg.sync_request = st.sync_request;
   end

   // every accepted write is logged for the link side; full fifo drops the log only
   assign rec.addr = reg_addr[7:0];
   assign rec.data = reg_wdata;
   assign reg_rdata = st.rdata;
   assign write_dropped = st.dropped;
   assign change_word = fifo_out;

   slcr_fifo #(
      .WIDTH(16),
      .DEPTH(slcr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(reg_wr),
      .in_ready(fifo_in_ready),
      .in_data(rec),
      .out_valid(change_valid),
      .out_ready(change_ready),
      .out_data(fifo_out)
   );
endmodule

// ### shared/slcr_pkg.sv
// package for the serial link configuration register bank
package slcr_pkg;
   // ***************************************
   // register offsets
   // ***************************************
   localparam logic [11:0] OFS_LINK_ENABLE = 12'h200;
   localparam logic [11:0] OFS_LINK_OUTPUT_MODE = 12'h201;
   localparam logic [11:0] OFS_MULTIFRAME_LENGTH = 12'h202;
   localparam logic [11:0] OFS_SOFTWARE_SYNC_REQUEST = 12'h203;
   localparam logic [11:0] OFS_LINK_CONTROL = 12'h204;
   localparam logic [11:0] OFS_LANE_TEST_PATTERN = 12'h205;
   localparam logic [11:0] OFS_LINK_DEVICE_IDENT = 12'h206;
   localparam logic [11:0] OFS_CAL_ENABLE = 12'h20D;
   localparam logic [11:0] OFS_LINK_STATUS = 12'h20E;
   // ***************************************
   // reset values and fields
   // ***************************************
   localparam logic [7:0] RST_LINK_ENABLE = 8'h01;
   localparam logic [4:0] RST_LINK_OUTPUT_MODE = 5'h02;
   localparam logic [4:0] RST_MULTIFRAME_LENGTH = 5'h1F;
   localparam logic RST_SOFTWARE_SYNC_REQUEST = 1'h1;
   localparam logic [1:0] RST_SYNC_SOURCE = 2'h0;
   localparam logic RST_SAMPLE_ENCODING = 1'h1;
   localparam logic RST_SCRAMBLER_ENABLE = 1'h0;
   localparam logic [3:0] RST_LANE_TEST_PATTERN = 4'h0;
   localparam logic [7:0] RST_LINK_DEVICE_IDENT = 8'h00;
   localparam logic RST_CAL_ENABLE = 1'h0;
   localparam int POS_SYNC_SOURCE = 2;
   localparam int POS_SAMPLE_ENCODING = 1;
   localparam int POS_SCRAMBLER_ENABLE = 0;
   localparam int FIFO_DEPTH = 8;
   // ***************************************
   // enumerations
   // ***************************************
   typedef enum logic [1:0] {
      SYNC_SRC_SINGLE_ENDED = 2'h0,
      SYNC_SRC_TIMESTAMP = 2'h1,
      SYNC_SRC_SOFTWARE = 2'h2,
      SYNC_SRC_RESERVED = 2'h3
   } slcr_sync_src_t;
   typedef enum logic [3:0] {
      TEST_NORMAL = 4'h0,
      TEST_PRBS7 = 4'h1,
      TEST_PRBS15 = 4'h2,
      TEST_PRBS23 = 4'h3,
      TEST_RAMP = 4'h4,
      TEST_TRANSPORT = 4'h5,
      TEST_D21_5 = 4'h6,
      TEST_K28_5 = 4'h7,
      TEST_REPEAT_ILA = 4'h8,
      TEST_MOD_RPAT = 4'h9,
      TEST_HOLD_LOW = 4'hA,
      TEST_HOLD_HIGH = 4'hB
   } slcr_test_t;
   // ***************************************
   // carriers
   // ***************************************
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } slcr_bus_req_t;
   typedef struct packed {
      logic link_enable;
      logic [4:0] link_output_mode;
      logic [4:0] multiframe_length;
      logic sample_encoding;
      logic scrambler_enable;
      logic [3:0] lane_test_pattern;
      logic test_reserved;
      logic [7:0] ident_link_a;
      logic [7:0] ident_link_b;
      logic sync_request;
      logic link_hold_reset;
      logic timestamp_receiver_enable;
   } slcr_link_cfg_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } slcr_word_t;
endpackage

// ### hw/slcr_fifo.sv
// parameterised FIFO carrying configuration change records
`timescale 1ns/10ps
module slcr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
   } slcr_fifo_st_t;
   slcr_fifo_st_t st;
   slcr_fifo_st_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   assign in_ready = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[st.rp];
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // storage needs no reset; only written entries are read
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[st.wp] <= in_data;
      end
   end
endmodule

// ### sim/slcr_sink.sv
// far-side drain model for the change record stream
`timescale 1ns/10ps
module slcr_sink (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // record stream
   input wire logic change_valid,
   input wire slcr_pkg::slcr_word_t change_word,
   output logic change_ready,
   // bench control and view
   input wire logic stall,
   output logic pop,
   output logic [15:0] word
);
   // random gaps so the head word has to hold while it is not taken
   always @(posedge core_clk) begin
      if (reset) begin
         change_ready <= 1'b0;
      end else begin
         change_ready <= !stall && ($urandom % 3 != 0);
      end
   end
   assign pop = change_valid && change_ready;
   assign word = change_word;
endmodule

// ### sim/slcr_regs_chk.sv
// assertion checker for the link configuration register bank
`timescale 1ns/10ps
module slcr_regs_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pin and link side
   input wire logic single_ended_sync_pin_n,
   input wire slcr_pkg::slcr_link_cfg_t link_cfg
);
   logic [1:0] src;
   logic sw;
   logic [3:0] tst;
   default clocking @(posedge core_clk); endclocking
   default disable iff reset;
   // shadow copy updates on the same edge as the bank, so no offset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         src <= 2'h0;
         sw <= 1'b1;
      end else if (reg_wr && reg_addr == 12'h204) begin
         src <= reg_wdata[3:2];
      end else if (reg_wr && reg_addr == 12'h203) begin
         sw <= reg_wdata[0];
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tst <= 4'h0;
      end else if (reg_wr && reg_addr == 12'h205) begin
         tst <= reg_wdata[3:0];
      end
   end
   property p_ident;
      !link_cfg.ident_link_a[0] && link_cfg.ident_link_b == link_cfg.ident_link_a + 8'h01;
   endproperty
   a_ident: assert property (p_ident) else $error("ident pair wrong");
   property p_mode_gate;
      reg_wr && reg_addr == 12'h201 && link_cfg.link_enable |=> $stable(link_cfg.link_output_mode);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("mode written while enabled");
   property p_sw_sync;
      !sw |-> link_cfg.sync_request;
   endproperty
   a_sw_sync: assert property (p_sw_sync) else $error("software sync ignored");
   property p_release;
      src[1] && sw |-> !link_cfg.sync_request;
   endproperty
   a_release: assert property (p_release) else $error("sync not released");
   property p_pin_sync;
      (src == 2'h0 && !single_ended_sync_pin_n) [*4] |-> link_cfg.sync_request;
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("pin sync missed");
   property p_reserved;
      link_cfg.lane_test_pattern == tst && link_cfg.test_reserved == (tst > 4'hB);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved flag wrong");
   property p_hold;
      !link_cfg.link_enable |-> link_cfg.link_hold_reset;
   endproperty
   a_hold: assert property (p_hold) else $error("link not held");
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_len_rd;
      reg_rd && reg_addr == 12'h202 |=> reg_rdata == {3'h0, $past(link_cfg.multiframe_length)};
   endproperty
   a_len_rd: assert property (p_len_rd) else $error("length read wrong");
endmodule
bind slcr_regs slcr_regs_chk u_slcr_regs_chk (.core_clk(core_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .single_ended_sync_pin_n(single_ended_sync_pin_n),
   .link_cfg(link_cfg));

// ### sim/slcr_regs_bench.sv
// self-checking bench for the link configuration register bank
`timescale 1ns/10ps
module slcr_regs_bench;
   logic core_clk, reset, reg_wr, reg_rd, se_n, ts_n, stall, pop, change_ready;
   logic change_valid, write_dropped, drop_next;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [15:0] word;
   logic [15:0] q[$];
   logic [7:0] rv[7] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00, 8'h00};
   slcr_pkg::slcr_link_cfg_t link_cfg;
   slcr_pkg::slcr_word_t change_word;
   int miscompares, checks_done, seed;
   slcr_regs u_slcr_regs (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .single_ended_sync_pin_n(se_n), .timestamp_diff_input_n(ts_n), .link_cfg(link_cfg),
      .change_valid(change_valid), .change_ready(change_ready), .change_word(change_word),
      .write_dropped(write_dropped));
   slcr_sink u_slcr_sink (.core_clk(core_clk), .reset(reset), .change_valid(change_valid),
      .change_word(change_word), .change_ready(change_ready), .stall(stall), .pop(pop),
      .word(word));
   function automatic logic [7:0] even_ident(input logic [7:0] v);
      return v & 8'hFE;
   endfunction
   task automatic end_sim;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      if (!drop_next) q.push_back({a[7:0], v});
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      cmp("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // pin path is two flops deep (se_sync[0], then sync_request), four edges covers it
   task automatic chk_sync(input logic e);
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      cmp("sync_request", {15'h0, e}, {15'h0, link_cfg.sync_request});
   endtask
   task automatic drain;
      int n = 0;
      while ((change_valid !== 1'b0 || q.size() != 0) && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 500) begin
         miscompares++;
         $display("ERROR drain expected empty seen busy");
         end_sim();
      end
   endtask
   always @(posedge core_clk) begin
      if (pop) begin
         cmp("change_word", q.pop_front(), word);
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      miscompares++;
      $display("ERROR watchdog expected end seen hang");
      end_sim();
   end
   initial begin
      {reset, reg_wr, reg_rd, stall, drop_next} = 5'h10;
      {se_n, ts_n} = 2'h3;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      seed = $urandom(32'hc895);
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 7; i++) rd(12'h200 + 12'(i), rv[i]);
      rd(12'h210, 8'h00);
      rd(12'h20E, 8'h03);
      $display("test reset values done");
      wr(12'h201, 8'h0A);
      rd(12'h201, 8'h02);
      wr(12'h200, 8'h00);
      @(negedge core_clk);
      cmp("link_hold_reset", 16'h1, {15'h0, link_cfg.link_hold_reset});
      wr(12'h201, 8'h0A);
      rd(12'h201, 8'h0A);
      cmp("link_output_mode", 16'h000A, {11'h0, link_cfg.link_output_mode});
      $display("test mode gate done");
      // link stays disabled for every write below
      for (int i = 0; i < 16; i++) begin
         d = (i == 15) ? 8'hFF : 8'($urandom);
         wr(12'h205, 8'(i));
         wr(12'h206, d);
         wr(12'h202, {3'h0, d[4:0]}); // legality left to software
         wr(12'h204, {6'h00, d[6:5]});
         rd(12'h205, 8'(i));
         cmp("test_reserved", 16'(i > 11), {15'h0, link_cfg.test_reserved});
         rd(12'h206, even_ident(d));
         cmp("ident_link_b", 16'(even_ident(d) + 8'h01), 16'(link_cfg.ident_link_b));
         rd(12'h202, {3'h0, d[4:0]});
         rd(12'h204, {6'h00, d[6:5]});
         cmp("encoding_scrambler", {14'h0, d[6:5]},
            {14'h0, link_cfg.sample_encoding, link_cfg.scrambler_enable});
         cmp("ident_link_a", {8'h00, even_ident(d)}, {8'h00, link_cfg.ident_link_a});
         cmp("multiframe_length", {11'h0, d[4:0]}, {11'h0, link_cfg.multiframe_length});
      end
      $display("test fields done");
      wr(12'h204, 8'h08);
      wr(12'h203, 8'h00);
      chk_sync(1'b1);
      wr(12'h203, 8'h01);
      chk_sync(1'b0);
      wr(12'h204, 8'h00);
      se_n <= 1'b0;
      chk_sync(1'b1);
      wr(12'h204, 8'h08);
      chk_sync(1'b0);
      @(posedge core_clk);
      se_n <= 1'b1;
      wr(12'h20D, 8'h02);
      rd(12'h20D, 8'h02);
      cmp("timestamp_receiver_enable", 16'h1, {15'h0, link_cfg.timestamp_receiver_enable});
      wr(12'h204, 8'h04);
      ts_n <= 1'b0;
      chk_sync(1'b1);
      @(posedge core_clk);
      ts_n <= 1'b1;
      chk_sync(1'b0);
      $display("test sync done");
      drain();
      stall <= 1'b1;
      for (int i = 0; i < 8; i++) wr(12'h210, 8'(i));
      drop_next = 1'b1;
      wr(12'h210, 8'hEE);
      @(negedge core_clk);
      cmp("write_dropped", 16'h1, {15'h0, write_dropped});
      drop_next = 1'b0;
      stall <= 1'b0;
      drain();
      cmp("queue_left", 16'h0, 16'(q.size()));
      $display("test fifo done");
      end_sim();
   end
endmodule
